// *** shared/iocb_pkg.sv ***
// Package for the IO configuration bank: offsets, field positions, reset values and timing
package iocb_pkg;
    // Register offsets (register space A)
    localparam logic [7:0] ANT_CLK_CFG_OFS = 8'h00;
    localparam logic [7:0] SUP_PIN_CFG_OFS = 8'h01;
    localparam logic [7:0] OP_CTRL_OFS     = 8'h02;

    // Field positions, antenna/clock register
    localparam int SINGLE_ENDED_BIT  = 7;
    localparam int SECOND_DRV_BIT    = 6;
    localparam int HOLD_SEL_HI_BIT   = 5;
    localparam int HOLD_SEL_LO_BIT   = 4;
    localparam int CLK_SEL_HI_BIT    = 2;
    localparam int CLK_SEL_LO_BIT    = 1;
    localparam int LF_CLK_DIS_BIT    = 0;
    localparam logic [7:0] ANT_CLK_WMASK = 8'hf7;

    // Field positions, supply/pin register
    localparam int LOW_SUPPLY_BIT    = 7;
    localparam int DIG_REG_OFF_BIT   = 6;
    localparam int TUNE_DAC_EN_BIT   = 5;
    localparam int PD_SELECTED_BIT   = 4;
    localparam int PD_DESELECTED_BIT = 3;
    localparam int DRIVE_BOOST_BIT   = 2;
    localparam int MOD_REF_SEL_BIT   = 1;
    localparam int ACTIVE_SINK_BIT   = 0;

    // Operation control register
    localparam int OSC_EN_BIT        = 7;

    localparam logic [7:0] REG_RESET  = 8'h00;
    localparam logic [7:0] READ_ZERO  = 8'h00;

    // Host clock divider: 27.12 MHz crystal divided by 8, 4, 2
    localparam logic [1:0] CLK_SEL_3M39  = 2'h0;
    localparam logic [1:0] CLK_SEL_6M78  = 2'h1;
    localparam logic [1:0] CLK_SEL_13M56 = 2'h2;
    localparam logic [1:0] CLK_SEL_OFF   = 2'h3;

    // I2C hold time per setting, in ns
    localparam int HOLD_NS_380 = 380;
    localparam int HOLD_NS_180 = 180;
    localparam int HOLD_NS_160 = 160;
    localparam int HOLD_NS_100 = 100;
    localparam int HOLD_NS_70  = 70;
    localparam int CLK_PERIOD_NS = 20;

    typedef enum logic [1:0] {
        IOCB_SRC_LOW,
        IOCB_SRC_LF,
        IOCB_SRC_XTAL
    } iocb_src_type;

    typedef struct packed {
        logic       single_ended;
        logic       driver_one_en;
        logic       driver_two_en;
        logic       input_one_en;
        logic       input_two_en;
    } iocb_antenna_type;

    typedef struct packed {
        logic       dac_active;
        logic       hold_fixed;
    } iocb_tune_type;
endpackage : iocb_pkg

// *** src/iocb_bank.sv ***
// IO configuration bank: antenna, host clock, I2C hold, pull-down and drive controls
//
// Our own choice: strobed register access.
`timescale 1ns/1ps

module iocb_bank #(
    parameter int HOLD_W = 5
) (
    // Clock, reset, enable
    input  wire logic                         i_mclk,
    input  wire logic                         i_rst,
    input  wire logic                         i_ce,
    // Register port
    input  wire logic [7:0]                   i_addr,
    input  wire logic [7:0]                   i_wdata,
    input  wire logic                         i_wr,
    input  wire logic                         i_rd,
    output logic      [7:0]                   o_rdata,
    // Clock sources
    input  wire logic                         i_xtal_clk,
    input  wire logic                         i_xtal_running,
    input  wire logic                         i_lf_clk,
    // Host interface state
    input  wire logic                         i_spi_mode,
    input  wire logic                         i_spi_chip_select,
    input  wire logic                         i_miso_driven,
    // Antenna and analog controls
    output iocb_pkg::iocb_antenna_type        o_antenna,
    output iocb_pkg::iocb_tune_type           o_tune,
    output logic                              o_osc_enable,
    output logic                              o_low_supply_select,
    output logic                              o_dig_reg_off,
    output logic                              o_modulation_regulator_ref_sel,
    output logic                              o_active_sink,
    // Host pins
    output logic                              o_host_clk,
    output logic                              o_miso_pulldown,
    output logic                              o_drive_boost,
    output logic      [HOLD_W-1:0]            o_i2c_hold_cycles_normal,
    output logic      [HOLD_W-1:0]            o_i2c_hold_cycles_fast
);
    logic [7:0] ant_clk_reg;
    logic [7:0] sup_pin_reg;
    logic [7:0] op_ctrl_reg;
    logic       osc_seen_reg;
    logic [2:0] div_reg;
    logic       xtal_d_reg;
    logic       lf_d_reg;
    logic       xtal_edge;
    logic       lf_edge;
    logic       src_tick;
    logic       src_level;
    logic [1:0] clk_sel;
    iocb_pkg::iocb_src_type src_reg;
    iocb_pkg::iocb_src_type src_next;

    function automatic logic [HOLD_W-1:0] ns_to_cycles(input int ns);
        int cyc;
        cyc = (ns + iocb_pkg::CLK_PERIOD_NS - 1) / iocb_pkg::CLK_PERIOD_NS;
        return HOLD_W'(cyc);
    endfunction : ns_to_cycles

    // Register writes
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            ant_clk_reg <= iocb_pkg::REG_RESET;
            sup_pin_reg <= iocb_pkg::REG_RESET;
            op_ctrl_reg <= iocb_pkg::REG_RESET;
        end else if (i_ce && i_wr) begin
            case (i_addr)
                iocb_pkg::ANT_CLK_CFG_OFS: ant_clk_reg <= i_wdata & iocb_pkg::ANT_CLK_WMASK;
                iocb_pkg::SUP_PIN_CFG_OFS: sup_pin_reg <= i_wdata;
                iocb_pkg::OP_CTRL_OFS:     op_ctrl_reg <= i_wdata;
                default: begin
                end
            endcase
        end
    end

    // Read data one cycle after the strobe, zero after an enabled cycle without one, held while i_ce is low
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            o_rdata <= iocb_pkg::READ_ZERO;
        end else if (i_ce) begin
            if (i_rd) begin
                case (i_addr)
                    iocb_pkg::ANT_CLK_CFG_OFS: o_rdata <= ant_clk_reg;
                    iocb_pkg::SUP_PIN_CFG_OFS: o_rdata <= sup_pin_reg;
                    iocb_pkg::OP_CTRL_OFS:     o_rdata <= op_ctrl_reg;
                    default:                   o_rdata <= iocb_pkg::READ_ZERO;
                endcase
            end else begin
                o_rdata <= iocb_pkg::READ_ZERO;
            end
        end
    end

    // Fixed tuning value needs the oscillator to have been enabled once
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            osc_seen_reg <= 1'b0;
        end else if (i_ce && op_ctrl_reg[iocb_pkg::OSC_EN_BIT]) begin
            osc_seen_reg <= 1'b1;
        end
    end

    assign o_osc_enable = op_ctrl_reg[iocb_pkg::OSC_EN_BIT];

    // Antenna drive selection
    always_comb begin
        o_antenna.single_ended  = ant_clk_reg[iocb_pkg::SINGLE_ENDED_BIT];
        if (!ant_clk_reg[iocb_pkg::SINGLE_ENDED_BIT]) begin
            o_antenna.driver_one_en = 1'b1;
            o_antenna.driver_two_en = 1'b1;
            o_antenna.input_one_en  = 1'b1;
            o_antenna.input_two_en  = 1'b1;
        end else begin
            o_antenna.driver_one_en = !ant_clk_reg[iocb_pkg::SECOND_DRV_BIT];
            o_antenna.driver_two_en = ant_clk_reg[iocb_pkg::SECOND_DRV_BIT];
            o_antenna.input_one_en  = !ant_clk_reg[iocb_pkg::SECOND_DRV_BIT];
            o_antenna.input_two_en  = ant_clk_reg[iocb_pkg::SECOND_DRV_BIT];
        end
    end

    // Tuning converters
    always_comb begin
        o_tune.dac_active = sup_pin_reg[iocb_pkg::TUNE_DAC_EN_BIT] && o_osc_enable;
        o_tune.hold_fixed = sup_pin_reg[iocb_pkg::TUNE_DAC_EN_BIT] && !o_osc_enable && osc_seen_reg;
    end

    // Plain analog fields
    assign o_low_supply_select            = sup_pin_reg[iocb_pkg::LOW_SUPPLY_BIT];
    assign o_dig_reg_off                  = sup_pin_reg[iocb_pkg::DIG_REG_OFF_BIT];
    assign o_modulation_regulator_ref_sel = sup_pin_reg[iocb_pkg::MOD_REF_SEL_BIT];
    assign o_active_sink                  = sup_pin_reg[iocb_pkg::ACTIVE_SINK_BIT];
    assign o_drive_boost                  = sup_pin_reg[iocb_pkg::DRIVE_BOOST_BIT];

    // MISO pull-downs, only while the host port is in SPI mode
    always_comb begin
        o_miso_pulldown = 1'b0;
        if (i_spi_mode) begin
            if (sup_pin_reg[iocb_pkg::PD_SELECTED_BIT] && !i_spi_chip_select && !i_miso_driven) begin
                o_miso_pulldown = 1'b1;
            end
            if (sup_pin_reg[iocb_pkg::PD_DESELECTED_BIT] && i_spi_chip_select) begin
                o_miso_pulldown = 1'b1;
            end
        end
    end

    // I2C hold time, in system clock cycles rounded up
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            o_i2c_hold_cycles_normal <= '0;
            o_i2c_hold_cycles_fast   <= '0;
        end else if (i_ce) begin
            case ({ant_clk_reg[iocb_pkg::HOLD_SEL_HI_BIT], ant_clk_reg[iocb_pkg::HOLD_SEL_LO_BIT]})
                2'h0: begin
                    o_i2c_hold_cycles_normal <= ns_to_cycles(iocb_pkg::HOLD_NS_380);
                    o_i2c_hold_cycles_fast   <= ns_to_cycles(iocb_pkg::HOLD_NS_160);
                end
                2'h1: begin
                    o_i2c_hold_cycles_normal <= ns_to_cycles(iocb_pkg::HOLD_NS_180);
                    o_i2c_hold_cycles_fast   <= ns_to_cycles(iocb_pkg::HOLD_NS_160);
                end
                2'h2: begin
                    o_i2c_hold_cycles_normal <= ns_to_cycles(iocb_pkg::HOLD_NS_180);
                    o_i2c_hold_cycles_fast   <= ns_to_cycles(iocb_pkg::HOLD_NS_70);
                end
                default: begin
                    o_i2c_hold_cycles_normal <= ns_to_cycles(iocb_pkg::HOLD_NS_100);
                    o_i2c_hold_cycles_fast   <= ns_to_cycles(iocb_pkg::HOLD_NS_70);
                end
            endcase
        end
    end

    // Host clock. Crystal and LF clocks are taken as synchronous level inputs
    // and sampled; the crystal-derived output is therefore a divided sample.
    assign clk_sel   = {ant_clk_reg[iocb_pkg::CLK_SEL_HI_BIT], ant_clk_reg[iocb_pkg::CLK_SEL_LO_BIT]};
    assign xtal_edge = i_xtal_clk && !xtal_d_reg;
    assign lf_edge   = i_lf_clk && !lf_d_reg;

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            xtal_d_reg <= 1'b0;
            lf_d_reg   <= 1'b0;
            div_reg    <= 3'h0;
        end else if (i_ce) begin
            xtal_d_reg <= i_xtal_clk;
            lf_d_reg   <= i_lf_clk;
            if (xtal_edge) begin
                div_reg <= div_reg + 3'h1;
            end
        end
    end

    // Selected source level and switch-safe flag, high for as long as the current source is low
    always_comb begin
        src_level = 1'b0;
        src_tick  = 1'b1;
        case (src_reg)
            iocb_pkg::IOCB_SRC_XTAL: begin
                case (clk_sel)
                    iocb_pkg::CLK_SEL_3M39:  src_level = div_reg[2];
                    iocb_pkg::CLK_SEL_6M78:  src_level = div_reg[1];
                    default:                 src_level = div_reg[0];
                endcase
                src_tick = !src_level;
            end
            iocb_pkg::IOCB_SRC_LF: begin
                src_level = lf_d_reg;
                src_tick  = !lf_d_reg;
            end
            default: begin
                src_level = 1'b0;
                src_tick  = 1'b1;
            end
        endcase
    end

    always_comb begin
        if (clk_sel == iocb_pkg::CLK_SEL_OFF) begin
            src_next = iocb_pkg::IOCB_SRC_LOW;
        end else if (i_xtal_running) begin
            src_next = iocb_pkg::IOCB_SRC_XTAL;
        end else if (!ant_clk_reg[iocb_pkg::LF_CLK_DIS_BIT]) begin
            src_next = iocb_pkg::IOCB_SRC_LF;
        end else begin
            src_next = iocb_pkg::IOCB_SRC_LOW;
        end
    end

    // Switch sources only while the output is low, so no pulse is cut short
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            src_reg    <= iocb_pkg::IOCB_SRC_LOW;
            o_host_clk <= 1'b0;
        end else if (i_ce) begin
            if (src_tick && !o_host_clk) begin
                src_reg <= src_next;
            end
            o_host_clk <= src_level;
        end
    end
endmodule : iocb_bank

// *** verif/iocb_bank_chk.sv ***
// Concurrent checks on the IO configuration bank ports
`timescale 1ns/1ps
module iocb_bank_chk #(
    parameter int HOLD_W = 5
) (
    // Clock, reset, register port and SPI mode
    input wire logic                  i_mclk, i_rst, i_ce, i_wr, i_rd, i_spi_mode,
    input wire logic [7:0]            i_addr, i_wdata, o_rdata,
    // Configuration outputs
    input wire iocb_pkg::iocb_antenna_type o_antenna,
    input wire iocb_pkg::iocb_tune_type    o_tune,
    input wire logic                  o_osc_enable, o_host_clk, o_miso_pulldown, o_drive_boost,
    input wire logic [HOLD_W-1:0]     o_i2c_hold_cycles_normal, o_i2c_hold_cycles_fast
);
    logic off_q;
    // Shadow of the held-low clock setting, so the check does not trust the bank itself
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) off_q <= 1'b0;
        else if (i_ce && i_wr && i_addr == 8'h00) off_q <= &i_wdata[2:1];
    end
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    a_diff_both: assert property (
        !o_antenna.single_ended |-> o_antenna.driver_one_en && o_antenna.driver_two_en) else $error("driver lost");
    a_single_pair: assert property (
        o_antenna.single_ended |-> (o_antenna.driver_one_en ^ o_antenna.driver_two_en)
        && o_antenna.input_two_en == o_antenna.driver_two_en) else $error("pair wrong");
    a_drv_sel: assert property (
        i_ce && i_wr && i_addr == 8'h00 && i_wdata[7] |=> o_antenna.driver_two_en == $past(i_wdata[6]))
        else $error("driver select");
    a_tune_gate: assert property (o_tune.dac_active |-> o_osc_enable) else $error("dac gate");
    a_fixed_hold: assert property (
        o_tune.hold_fixed |-> !o_osc_enable && !o_tune.dac_active) else $error("fixed hold");
    a_i2c_nopd: assert property (!i_spi_mode |-> !o_miso_pulldown) else $error("pull in i2c");
    a_rdata_idle: assert property (i_ce && !i_rd |=> o_rdata == 8'h00) else $error("rdata idle");
    a_wr_rd: assert property (
        i_ce && i_wr && i_addr == 8'h01 ##1 i_ce && i_rd && i_addr == 8'h01 |=> o_rdata == $past(i_wdata, 2))
        else $error("readback");
    a_boost_wr: assert property (
        i_ce && i_wr && i_addr == 8'h01 |=> o_drive_boost == $past(i_wdata[2])) else $error("boost");
    a_hold_upd: assert property (
        i_ce && i_wr && i_addr == 8'h00 && i_wdata[5:4] == 2'h3 |-> ##[1:3]
        (o_i2c_hold_cycles_normal == HOLD_W'(5) && o_i2c_hold_cycles_fast == HOLD_W'(4))) else $error("hold");
    a_clk_off: assert property (
        $rose(off_q) |-> ##[1:40] !o_host_clk [*8]) else $error("clock not held low");
    c_fixed: cover property (o_tune.hold_fixed);
    c_pull: cover property (o_miso_pulldown);
    c_hclk: cover property ($rose(o_host_clk));
endmodule : iocb_bank_chk

bind iocb_bank iocb_bank_chk #(.HOLD_W(HOLD_W)) u_chk (.i_mclk, .i_rst, .i_ce, .i_wr, .i_rd, .i_spi_mode,
    .i_addr, .i_wdata, .o_rdata, .o_antenna, .o_tune, .o_osc_enable, .o_host_clk, .o_miso_pulldown,
    .o_drive_boost, .o_i2c_hold_cycles_normal, .o_i2c_hold_cycles_fast);

// *** verif/iocb_host_model.sv ***
// Host-side model: makes the crystal and LF clocks and measures the host clock
`timescale 1ns/1ps
module iocb_host_model #(
    parameter int LF_HALF = 10
) (
    input  wire logic       i_mclk,
    input  wire logic       i_clear,
    input  wire logic       i_host_clk,
    output logic            o_xtal_clk,
    output logic            o_lf_clk,
    output logic [7:0]      o_period,
    output logic [7:0]      o_rises
);
    logic [7:0] cnt, lf_cnt;
    logic       host_q;
    initial begin
        {o_xtal_clk, o_lf_clk, host_q} = 3'h0;
        {cnt, lf_cnt, o_period, o_rises} = 32'h0;
    end
    // Crystal toggles every cycle, the fastest the bank's sampler can follow
    always @(posedge i_mclk) begin
        o_xtal_clk <= !o_xtal_clk;
        lf_cnt <= (lf_cnt == 8'(LF_HALF - 1)) ? 8'h00 : lf_cnt + 8'h01;
        if (lf_cnt == 8'(LF_HALF - 1)) o_lf_clk <= !o_lf_clk;
        host_q <= i_host_clk;
        cnt <= cnt + 8'h01;
        if (i_clear) o_rises <= 8'h00;
        else if (i_host_clk && !host_q) begin
            o_period <= cnt;
            cnt <= 8'h01;
            o_rises <= o_rises + 8'h01;
        end
    end
endmodule : iocb_host_model

// *** verif/tb_iocb_bank.sv ***
// Testbench for the IO configuration bank
`timescale 1ns/1ps
module tb_iocb_bank;
    logic mclk = 1'b0, rst = 1'b1, ce = 1'b1, wr = 1'b0, rd = 1'b0, clr = 1'b0;
    logic xrun = 1'b0, spi = 1'b1, cs = 1'b1, drv = 1'b0, xtal, lf, hclk, pd, osc, boost, lsup, dro, mref, asink;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, per, rises;
    logic [4:0] hn, hf;
    iocb_pkg::iocb_antenna_type ant;
    iocb_pkg::iocb_tune_type    tune;
    int fails = 0, total_checks = 0, cyc = 0;
    logic [9:0]  hx [4] = '{{5'h13, 5'h08}, {5'h09, 5'h08}, {5'h09, 5'h04}, {5'h05, 5'h04}};
    logic [15:0] hc [7] = '{16'h0010, 16'h0208, 16'h0404, 16'h0600, 16'h0014, 16'h0100, 16'h0600};
    logic [5:0]  pdt [7] = '{6'b101001, 6'b101010, 6'b101100, 6'b011101, 6'b011000, 6'b110100, 6'b110000};

    iocb_bank #(.HOLD_W(5)) DUT (.i_mclk(mclk), .i_rst(rst), .i_ce(ce), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_xtal_clk(xtal), .i_xtal_running(xrun), .i_lf_clk(lf),
        .i_spi_mode(spi), .i_spi_chip_select(cs), .i_miso_driven(drv), .o_antenna(ant), .o_tune(tune),
        .o_osc_enable(osc), .o_low_supply_select(lsup), .o_dig_reg_off(dro), .o_modulation_regulator_ref_sel(mref),
        .o_active_sink(asink), .o_host_clk(hclk), .o_miso_pulldown(pd), .o_drive_boost(boost),
        .o_i2c_hold_cycles_normal(hn), .o_i2c_hold_cycles_fast(hf));
    iocb_host_model #(.LF_HALF(10)) u_host (.i_mclk(mclk), .i_clear(clr), .i_host_clk(hclk),
        .o_xtal_clk(xtal), .o_lf_clk(lf), .o_period(per), .o_rises(rises));

    always #10 mclk = ~mclk;
    // Whole run needs under 2000 cycles
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 4000) begin
            fails++;
            results();
        end
    end

    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic wr_reg(input logic [7:0] a, d);
        @(posedge mclk); wr <= 1'b1; addr <= a; wdata <= d;
        @(posedge mclk); wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_chk(input logic [7:0] a, exp);
        @(posedge mclk); rd <= 1'b1; addr <= a;
        @(posedge mclk); rd <= 1'b0;
        @(negedge mclk); chk("rdata", exp, rdata);
    endtask : rd_chk
    task automatic wrrd(input logic [7:0] a, d);
        @(posedge mclk); wr <= 1'b1; addr <= a; wdata <= d;
        @(posedge mclk); wr <= 1'b0; rd <= 1'b1;
        @(posedge mclk); rd <= 1'b0;
        @(negedge mclk); chk("rdata", d, rdata);
    endtask : wrrd
    task automatic idle(input int n);
        repeat (n) @(posedge mclk);
        @(negedge mclk);
    endtask : idle
    task automatic results;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : results

    initial begin
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        for (int a = 0; a < 3; a++) rd_chk(8'(a), 8'h00);
        idle(1); chk("hold", {3'h0, hx[0][9:5]}, {3'h0, hn});
        wr_reg(8'h07, 8'hff); rd_chk(8'h07, 8'h00);
        wr_reg(8'h00, 8'hff); rd_chk(8'h00, 8'hf7);
        $display("test registers done");
        for (int k = 0; k < 4; k++) begin
            wr_reg(8'h00, {k[1:0], k[1:0], 4'h0});
            idle(3); chk("hold", {3'h0, hx[k][9:5]}, {3'h0, hn});
            chk("hold_fast", {3'h0, hx[k][4:0]}, {3'h0, hf});
            chk("antenna", {3'h0, k[1], ~(k[1] & k[0]), ~k[1] | k[0], ~(k[1] & k[0]), ~k[1] | k[0]}, ant);
        end
        $display("test antenna and hold done");
        for (int i = 0; i < 7; i++) begin
            wr_reg(8'h00, hc[i][15:8]); xrun <= (i < 4);
            idle(40); @(posedge mclk); clr <= 1'b1; @(posedge mclk); clr <= 1'b0; idle(60);
            if (hc[i][7:0] == 8'h00) chk("rises", 8'h00, rises);
            else chk("period", hc[i][7:0], per);
        end
        $display("test host clock done");
        for (int i = 0; i < 7; i++) begin
            wr_reg(8'h01, {3'h0, pdt[i][5:4], 3'h0}); spi <= pdt[i][3]; cs <= pdt[i][2]; drv <= pdt[i][1];
            idle(1); chk("pulldown", {7'h0, pdt[i][0]}, {7'h0, pd});
        end
        $display("test pulldown done");
        wr_reg(8'h01, 8'h20); idle(1); chk("tune", 8'h00, {6'h0, tune});
        wr_reg(8'h02, 8'h80); idle(1); chk("tune", 8'h02, {6'h0, tune}); chk("osc", 8'h01, {7'h0, osc});
        wr_reg(8'h02, 8'h00); idle(1); chk("tune", 8'h01, {6'h0, tune});
        $display("test tuning done");
        @(posedge mclk); ce <= 1'b0;
        wr_reg(8'h01, 8'hff); ce <= 1'b1;
        rd_chk(8'h01, 8'h20);
        wrrd(8'h01, 8'hff);
        idle(1); chk("supply_pins", 8'h1f, {3'h0, lsup, dro, boost, mref, asink});
        $display("test supply pins done");
        results();
    end
endmodule : tb_iocb_bank
